// [rtl/pci_target_wide_local_port.sv]
`timescale 1ns/1ps
// Behaviour
// - Local address goes to the back-end one clock after the address phase.
// - Wide-transfer flag goes low with the local address on a wide request.
// - Window match signals follow one clock after decoding starts.
// - Slow select timing asserts device select one clock after window match.
// - Wide acknowledge asserts together with device select for a wide request.
// - Target ready asserts in the clock after back-end ready for a write; a read waits one more clock for the fetched word.
// - Transaction end clears window match and both half strobes.
// - Narrow bus needs two data phases per local word.
// - Whole local word is latched and the proper half routed to the bus.
// - Separate lower and upper strobes mark which half moves.
// - Aligned start moves the lower half first, otherwise the upper half.
module pci_target_wide_local_port #(
  parameter int NUM_WIN = 2,
  parameter logic [NUM_WIN*32-1:0] WIN_BASE = {32'h2000_0000, 32'h1000_0000},
  parameter logic [NUM_WIN*32-1:0] WIN_MASK = {32'hF000_0000, 32'hF000_0000},
  parameter bit BUS_64 = 1'b1,
  parameter bit SELECT_RESPONSE_SPEED_SLOW = 1'b1
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic FRAME_N_IN,
  input wire logic REQ64_N_IN,
  input wire logic IRDY_N_IN,
  input wire logic [pci_target_pkg::DATA_W-1:0] AD_IN,
  input wire logic [pci_target_pkg::BE_W-1:0] CBE_N_IN,
  output logic [pci_target_pkg::DATA_W-1:0] AD_OUT,
  output logic AD_OE_N_OUT,
  output logic DEVSEL_N_OUT,
  output logic TRDY_N_OUT,
  output logic ACK64_N_OUT,
  output logic CTL_OE_N_OUT,
  output logic [pci_target_pkg::ADDR_W-1:0] LOCAL_ADDR_TO_BACKEND_OUT,
  output logic [pci_target_pkg::CMD_W-1:0] LOCAL_CMD_OUT,
  output logic WIDE_TRANSFER_FLAG_N_OUT,
  output logic [NUM_WIN-1:0] WINDOW_MATCH_OUT,
  input wire logic BACKEND_READY_N_IN,
  output logic UPPER_HALF_STROBE_N_OUT,
  output logic LOWER_HALF_STROBE_N_OUT,
  input wire logic [pci_target_pkg::DATA_W-1:0] LOCAL_DATA_IN,
  output logic [pci_target_pkg::DATA_W-1:0] LOCAL_DATA_OUT,
  output logic [pci_target_pkg::BE_W-1:0] LOCAL_BE_N_OUT
);
  import pci_target_pkg::*;

  state_type state_reg, state_next;
  req_type req_reg;
  logic prev_frame_n_reg;
  logic wide_flag_n_reg;
  logic [NUM_WIN-1:0] match_reg;
  logic devsel_n_reg;
  logic trdy_n_reg;
  logic ack64_n_reg;
  logic ctl_oe_n_reg;
  logic ad_oe_n_reg;
  logic upper_half_reg;
  logic qword_valid_reg, qword_valid_next;
  logic [DATA_W-1:0] qword_reg;
  logic [DATA_W-1:0] ad_out_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic [BE_W-1:0] wr_be_n_reg;
  strobe_type strobe_reg, strobe_next;

  // Decode and selection
  wire [NUM_WIN-1:0] hit_vec;
  wire [DATA_W-1:0] routed_bus;
  wire [DATA_W-1:0] routed_qword;
  wire [BE_W-1:0] routed_be_n;
  wire start = (state_reg == ST_IDLE) && prev_frame_n_reg && !FRAME_N_IN;
  wire is_read = (req_reg.cmd == CMD_MEM_READ);
  wire is_write = (req_reg.cmd == CMD_MEM_WRITE);
  wire any_hit = (|hit_vec) && (is_read || is_write);
  wire wide_mode = BUS_64 && req_reg.wide;
  wire data_xfer = (state_reg == ST_SELECT) && !IRDY_N_IN && !trdy_n_reg;
  wire last_xfer = data_xfer && FRAME_N_IN;
  wire aborted = (state_reg == ST_SELECT) && FRAME_N_IN && IRDY_N_IN;
  wire backend_ready = !BACKEND_READY_N_IN;
  wire in_select_next = (state_next == ST_SELECT);
  wire strobe_idle = (strobe_reg == STROBE_IDLE);
  wire rd_fetch = (state_reg == ST_SELECT) && is_read && !qword_valid_reg && strobe_idle &&
                  backend_ready;
  wire rd_capture = is_read && !strobe_idle;
  wire [DATA_W-1:0] qword_view = rd_capture ? LOCAL_DATA_IN : qword_reg;
  wire rd_consume = data_xfer && is_read && (wide_mode || upper_half_reg);
  wire trdy_hold = !trdy_n_reg && IRDY_N_IN;
  wire trdy_go = backend_ready && (is_write || qword_valid_next);
  strobe_type half_strobe;
  assign half_strobe.upper_n = !(wide_mode || upper_half_reg);
  assign half_strobe.lower_n = !(wide_mode || !upper_half_reg);

  window_decoder #(
    .NUM_WIN(NUM_WIN),
    .WIN_BASE(WIN_BASE),
    .WIN_MASK(WIN_MASK)
  ) u_decoder (
    .addr_in(req_reg.addr),
    .hit_out(hit_vec)
  );

  half_router u_router (
    .qword_in(qword_view),
    .bus_in(AD_IN),
    .be_n_in(CBE_N_IN),
    .upper_in(upper_half_reg),
    .wide_in(wide_mode),
    .bus_out(routed_bus),
    .qword_out(routed_qword),
    .be_n_out(routed_be_n)
  );

  // Sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (!any_hit) begin
          state_next = ST_SKIP;
        end else if (SELECT_RESPONSE_SPEED_SLOW) begin
          state_next = ST_MATCH;
        end else begin
          state_next = ST_SELECT;
        end
      end
      ST_MATCH: begin
        state_next = ST_SELECT;
      end
      ST_SELECT: begin
        if (last_xfer || aborted) begin
          state_next = ST_TURN;
        end
      end
      ST_TURN: begin
        state_next = ST_IDLE;
      end
      ST_SKIP: begin
        if (FRAME_N_IN && IRDY_N_IN) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // Read word holding
  always_comb begin
    qword_valid_next = qword_valid_reg;
    if (state_reg == ST_TURN) begin
      qword_valid_next = 1'b0;
    end else if (rd_capture) begin
      qword_valid_next = 1'b1;
    end else if (rd_consume) begin
      qword_valid_next = 1'b0;
    end
  end

  // Half strobes toward the back-end
  always_comb begin
    strobe_next = STROBE_IDLE;
    if (data_xfer && is_write) begin
      strobe_next = half_strobe;
    end else if (rd_fetch) begin
      strobe_next = half_strobe;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_reg <= ST_IDLE;
      prev_frame_n_reg <= 1'b1;
      strobe_reg <= STROBE_IDLE;
      qword_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      prev_frame_n_reg <= FRAME_N_IN;
      strobe_reg <= strobe_next;
      qword_valid_reg <= qword_valid_next;
    end
  end

  // Address phase capture
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      req_reg <= REQ_RESET;
      wide_flag_n_reg <= 1'b1;
    end else if (start) begin
      req_reg <= {AD_IN[ADDR_W-1:0], CBE_N_IN[CMD_W-1:0], !REQ64_N_IN};
      wide_flag_n_reg <= REQ64_N_IN;
    end else if (state_reg == ST_TURN) begin
      wide_flag_n_reg <= 1'b1;
    end
  end

  // Window match
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || state_reg == ST_TURN || state_reg == ST_SKIP) begin
      match_reg <= '0;
    end else if (state_reg == ST_DECODE) begin
      match_reg <= any_hit ? hit_vec : '0;
    end
  end

  // Bus handshake lines
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      devsel_n_reg <= 1'b1;
      trdy_n_reg <= 1'b1;
      ack64_n_reg <= 1'b1;
      ctl_oe_n_reg <= 1'b1;
      ad_oe_n_reg <= 1'b1;
    end else begin
      devsel_n_reg <= !in_select_next;
      ack64_n_reg <= !(in_select_next && wide_mode);
      trdy_n_reg <= !(in_select_next && (trdy_hold || trdy_go));
      ctl_oe_n_reg <= !(in_select_next || state_next == ST_TURN);
      ad_oe_n_reg <= !(in_select_next && is_read);
    end
  end

  // Half tracking and data paths
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      upper_half_reg <= 1'b0;
      qword_reg <= DATA_RESET;
      ad_out_reg <= DATA_RESET;
      wr_data_reg <= DATA_RESET;
      wr_be_n_reg <= BE_OFF;
    end else begin
      if (start) begin
        upper_half_reg <= AD_IN[QWORD_SEL_BIT];
      end else if (data_xfer && !wide_mode) begin
        upper_half_reg <= !upper_half_reg;
      end
      if (rd_capture) begin
        qword_reg <= LOCAL_DATA_IN;
      end
      ad_out_reg <= routed_bus;
      if (data_xfer && is_write) begin
        wr_data_reg <= routed_qword;
        wr_be_n_reg <= routed_be_n;
      end
    end
  end

  assign AD_OUT = ad_out_reg;
  assign AD_OE_N_OUT = ad_oe_n_reg;
  assign DEVSEL_N_OUT = devsel_n_reg;
  assign TRDY_N_OUT = trdy_n_reg;
  assign ACK64_N_OUT = ack64_n_reg;
  assign CTL_OE_N_OUT = ctl_oe_n_reg;
  assign LOCAL_ADDR_TO_BACKEND_OUT = req_reg.addr;
  assign LOCAL_CMD_OUT = req_reg.cmd;
  assign WIDE_TRANSFER_FLAG_N_OUT = wide_flag_n_reg;
  assign WINDOW_MATCH_OUT = match_reg;
  assign UPPER_HALF_STROBE_N_OUT = strobe_reg.upper_n;
  assign LOWER_HALF_STROBE_N_OUT = strobe_reg.lower_n;
  assign LOCAL_DATA_OUT = wr_data_reg;
  assign LOCAL_BE_N_OUT = wr_be_n_reg;

  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  a_addr_after_phase: assert property (
    start |=> LOCAL_ADDR_TO_BACKEND_OUT == $past(AD_IN[ADDR_W-1:0]) &&
              state_reg == ST_DECODE)
    else $error("local address not presented after address phase");

  a_wide_flag_low: assert property (
    start && !REQ64_N_IN |=> !WIDE_TRANSFER_FLAG_N_OUT && LOCAL_ADDR_TO_BACKEND_OUT ==
                             $past(AD_IN[ADDR_W-1:0]))
    else $error("wide flag not low with local address");

  a_match_one_later: assert property (
    start ##1 any_hit |=> WINDOW_MATCH_OUT != '0)
    else $error("window match late after decode");

  a_devsel_slow: assert property (
    SELECT_RESPONSE_SPEED_SLOW && $rose(|match_reg) |-> devsel_n_reg ##1 !devsel_n_reg)
    else $error("device select not one clock after match");

  a_ack64_with_sel: assert property (
    $fell(devsel_n_reg) |-> (ack64_n_reg == !wide_mode))
    else $error("wide acknowledge not with device select");

  a_trdy_after_rdy: assert property (
    state_reg == ST_SELECT && is_write && backend_ready && !last_xfer && !aborted
    |=> !trdy_n_reg)
    else $error("target ready missing after back-end ready");

  a_end_clears: assert property (
    state_reg == ST_TURN |=> match_reg == '0 && strobe_reg == STROBE_IDLE ##1
                             match_reg == '0)
    else $error("match or strobes not cleared at end");

  a_two_phases: assert property (
    !wide_mode && data_xfer && !upper_half_reg && !FRAME_N_IN |=> upper_half_reg)
    else $error("narrow phase did not step to upper half");

  a_route_half: assert property (
    is_read && !wide_mode && !rd_capture |=>
    AD_OUT[HALF_W-1:0] == ($past(upper_half_reg) ? qword_reg[DATA_W-1:HALF_W] :
                           qword_reg[HALF_W-1:0]))
    else $error("wrong half routed to bus");

  a_one_half_only: assert property (
    !wide_mode && !strobe_idle |-> strobe_reg.upper_n != strobe_reg.lower_n)
    else $error("both half strobes on a narrow transfer");

  a_first_half: assert property (
    start |=> upper_half_reg == $past(AD_IN[QWORD_SEL_BIT]))
    else $error("first half does not follow alignment");

  a_write_strobe: assert property (
    data_xfer && is_write |=> !strobe_idle ##1 strobe_idle || state_reg == ST_SELECT)
    else $error("write strobe missing after data phase");

endmodule // pci_target_wide_local_port

// [pkg/pci_target_pkg.sv]
package pci_target_pkg;

  // Bus and local widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int HALF_W = 32;
  localparam int CMD_W = 4;
  localparam int BE_W = 8;
  localparam int HALF_BE_W = 4;

  // Memory commands claimed by the target
  localparam logic [CMD_W-1:0] CMD_MEM_READ = 4'h6;
  localparam logic [CMD_W-1:0] CMD_MEM_WRITE = 4'h7;

  // Address bit that selects the upper half of a local word
  localparam int QWORD_SEL_BIT = 2;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_RESET = 64'h0;
  localparam logic [BE_W-1:0] BE_OFF = 8'hFF;
  localparam logic [HALF_BE_W-1:0] HALF_BE_OFF = 4'hF;
  localparam logic [HALF_W-1:0] HALF_ZERO = 32'h0;

  // Captured address phase
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CMD_W-1:0] cmd;
    logic wide;
  } req_type;

  localparam req_type REQ_RESET = '0;

  // Per-half transfer strobes, active low
  typedef struct packed {
    logic upper_n;
    logic lower_n;
  } strobe_type;

  localparam strobe_type STROBE_IDLE = 2'h3;

  // Target sequencer
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_DECODE = 6'h02,
    ST_MATCH  = 6'h04,
    ST_SELECT = 6'h08,
    ST_TURN   = 6'h10,
    ST_SKIP   = 6'h20
  } state_type;

endpackage

// [rtl/window_decoder.sv]
`timescale 1ns/1ps
module window_decoder #(
  parameter int NUM_WIN = 2,
  parameter logic [NUM_WIN*32-1:0] WIN_BASE = '0,
  parameter logic [NUM_WIN*32-1:0] WIN_MASK = '0
) (
  input wire logic [pci_target_pkg::ADDR_W-1:0] addr_in,
  output logic [NUM_WIN-1:0] hit_out
);
  import pci_target_pkg::*;

  generate
    if (NUM_WIN < 1 || NUM_WIN > 6) begin : g_bad
      $error("window_decoder: NUM_WIN must be 1 to 6");
    end
    for (genvar i = 0; i < NUM_WIN; i++) begin : g_win
      wire [ADDR_W-1:0] base_w = WIN_BASE[i*32 +: 32];
      wire [ADDR_W-1:0] mask_w = WIN_MASK[i*32 +: 32];
      assign hit_out[i] = ((addr_in & mask_w) == (base_w & mask_w));
    end
  endgenerate

endmodule // window_decoder

// [rtl/half_router.sv]
`timescale 1ns/1ps
module half_router (
  input wire logic [pci_target_pkg::DATA_W-1:0] qword_in,
  input wire logic [pci_target_pkg::DATA_W-1:0] bus_in,
  input wire logic [pci_target_pkg::BE_W-1:0] be_n_in,
  input wire logic upper_in,
  input wire logic wide_in,
  output logic [pci_target_pkg::DATA_W-1:0] bus_out,
  output logic [pci_target_pkg::DATA_W-1:0] qword_out,
  output logic [pci_target_pkg::BE_W-1:0] be_n_out
);
  import pci_target_pkg::*;

  // Read side: whole word or the selected half on the low lanes
  wire [HALF_W-1:0] read_half = upper_in ? qword_in[DATA_W-1:HALF_W] : qword_in[HALF_W-1:0];
  assign bus_out = wide_in ? qword_in : {HALF_ZERO, read_half};

  // Write side: low lanes steered into the selected half
  wire [HALF_W-1:0] low_lanes = bus_in[HALF_W-1:0];
  wire [HALF_BE_W-1:0] low_be_n = be_n_in[HALF_BE_W-1:0];
  assign qword_out = wide_in ? bus_in : {low_lanes, low_lanes};
  assign be_n_out = wide_in ? be_n_in :
                    (upper_in ? {low_be_n, HALF_BE_OFF} : {HALF_BE_OFF, low_be_n});

endmodule // half_router

// [sim/pci_backend_model.sv]
`timescale 1ns/1ps
module pci_backend_model #(
  parameter logic [63:0] FIRST_WORD = 64'h1122_3344_5566_7788
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic selected_in,
  input wire logic upper_strobe_n_in,
  input wire logic lower_strobe_n_in,
  output logic ready_n_out,
  output logic [63:0] data_out
);
  logic [63:0] word_reg;
  logic [63:0] word_next;
  logic moved;
  // Advance only after a strobe in the previous clock
  assign moved = ~(upper_strobe_n_in & lower_strobe_n_in);
  assign word_next = moved ? word_reg + 64'h0101_0101_0101_0101 : word_reg;
  // Unselected data is not held
  assign data_out = selected_in ? word_reg : ~word_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word_reg <= FIRST_WORD;
      ready_n_out <= 1'b1;
    end else begin
      word_reg <= word_next;
      ready_n_out <= ~selected_in;
    end
  end
endmodule // pci_backend_model

// [sim/pci_target_wide_local_port_tb_top.sv]
`timescale 1ns/1ps
module pci_target_wide_local_port_tb_top;
  import pci_target_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic frame_n = 1'b1;
  logic req64_n = 1'b1;
  logic irdy_n = 1'b1;
  logic [63:0] ad_in = 64'h0;
  logic [7:0] cbe_n = 8'hFF;
  logic ready_n;
  logic [63:0] ldata_in;
  logic [63:0] ad_out;
  logic ad_oe_n, devsel_n, trdy_n, ack64_n, ctl_oe_n, wide_n, up_n, lo_n;
  logic [31:0] laddr;
  logic [3:0] lcmd;
  logic [1:0] match;
  logic [63:0] ldata_out;
  logic [7:0] lbe_n;
  int n_errors = 0;
  int check_count = 0;
  int t[11];
  logic [63:0] seen_ad, seen_word, seen_wdata;
  logic [7:0] seen_be;
  logic seen_flag;

  always #25 clk = ~clk;

  pci_target_wide_local_port dut (.CLK_IN(clk), .RST_IN(rst), .FRAME_N_IN(frame_n),
    .REQ64_N_IN(req64_n), .IRDY_N_IN(irdy_n), .AD_IN(ad_in), .CBE_N_IN(cbe_n),
    .AD_OUT(ad_out), .AD_OE_N_OUT(ad_oe_n), .DEVSEL_N_OUT(devsel_n), .TRDY_N_OUT(trdy_n),
    .ACK64_N_OUT(ack64_n), .CTL_OE_N_OUT(ctl_oe_n), .LOCAL_ADDR_TO_BACKEND_OUT(laddr),
    .LOCAL_CMD_OUT(lcmd), .WIDE_TRANSFER_FLAG_N_OUT(wide_n), .WINDOW_MATCH_OUT(match),
    .BACKEND_READY_N_IN(ready_n), .UPPER_HALF_STROBE_N_OUT(up_n),
    .LOWER_HALF_STROBE_N_OUT(lo_n), .LOCAL_DATA_IN(ldata_in), .LOCAL_DATA_OUT(ldata_out),
    .LOCAL_BE_N_OUT(lbe_n));

  pci_backend_model bem (.clk_in(clk), .rst_in(rst), .selected_in(|match),
    .upper_strobe_n_in(up_n), .lower_strobe_n_in(lo_n), .ready_n_out(ready_n),
    .data_out(ldata_in));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic mark(input int k, input bit cond, input int i);
    if (cond && t[k] < 0) t[k] = i;
  endtask

  // Single-phase master transaction, events stamped by cycle
  task automatic run_txn(input logic [31:0] addr, input logic [3:0] cmd, input logic wide,
      input logic [63:0] wdata);
    bit xfer;
    foreach (t[k]) t[k] = -1;
    @(posedge clk);
    frame_n <= 1'b0;
    req64_n <= ~wide;
    ad_in <= {32'h0, addr};
    cbe_n <= {4'hF, cmd};
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      if (t[0] < 0 && laddr === addr) seen_flag = wide_n;
      if (t[6] < 0 && t[7] < 0 && !(up_n & lo_n)) begin
        seen_word = ldata_in;
        seen_wdata = ldata_out;
        seen_be = lbe_n;
      end
      xfer = (trdy_n === 1'b0 && irdy_n === 1'b0);
      if (xfer && t[5] < 0) seen_ad = ad_out;
      mark(0, laddr === addr, i);
      mark(1, match !== 2'h0, i);
      mark(2, devsel_n === 1'b0, i);
      mark(3, ack64_n === 1'b0, i);
      mark(4, ready_n === 1'b0, i);
      mark(5, trdy_n === 1'b0, i);
      mark(6, up_n === 1'b0, i);
      mark(7, lo_n === 1'b0, i);
      mark(8, t[1] >= 0 && match === 2'h0, i);
      mark(9, ad_oe_n === 1'b0, i);
      mark(10, ctl_oe_n === 1'b0, i);
      @(posedge clk);
      if (i == 0) begin
        frame_n <= 1'b1;
        req64_n <= 1'b1;
        irdy_n <= 1'b0;
        cbe_n <= 8'h00;
        ad_in <= (cmd === CMD_MEM_WRITE) ? wdata : ~ad_in;
      end else if (xfer || i == 10) begin
        irdy_n <= 1'b1;
        cbe_n <= 8'hFF;
        ad_in <= ~ad_in;
      end
    end
  endtask

  task automatic test_reset;
    @(negedge clk);
    check({devsel_n, trdy_n, ack64_n, up_n, lo_n, match}, 7'h7C);
    check(lbe_n, 8'hFF);
    check(wide_n, 1'b1);
    check({ad_oe_n, ctl_oe_n}, 2'h3);
    check(ldata_out | ad_out, 64'h0);
  endtask

  task automatic test_wide_write;
    run_txn(32'h1000_0040, CMD_MEM_WRITE, 1'b1, 64'hA5A5_0001_5A5A_0002);
    check(t[0], 1);
    check(lcmd, CMD_MEM_WRITE);
    check(t[9], -1);
    check(t[10], t[2]);
    check(seen_flag, 1'b0);
    check(t[1] - t[0], 1);
    check(t[2] - t[1], 1);
    check(t[3], t[2]);
    check(t[5] - t[4], 1);
    check(t[6] - t[5], 1);
    check(t[7], t[6]);
    check(seen_wdata, 64'hA5A5_0001_5A5A_0002);
    check(seen_be, 8'h00);
    check(t[8] - t[6], 1);
  endtask

  task automatic test_read_aligned;
    run_txn(32'h2000_0010, CMD_MEM_READ, 1'b0, 64'h0);
    check(seen_flag, 1'b1);
    check(t[2] - t[1], 1);
    check(t[3], -1);
    check(t[7] >= 0 && (t[6] < 0 || t[6] > t[7]), 1'b1);
    check(t[5] - t[7], 1);
    check(seen_ad, {32'h0, seen_word[31:0]});
    check(t[9], t[2]);
  endtask

  task automatic test_wide_read;
    run_txn(32'h2000_0018, CMD_MEM_READ, 1'b1, 64'h0);
    check(seen_flag, 1'b0);
    check(t[3], t[2]);
    check(t[6], t[7]);
    check(t[5] - t[6], 1);
    check(seen_ad, seen_word);
    check(t[9], t[2]);
  endtask

  task automatic test_narrow_write;
    run_txn(32'h1000_0004, CMD_MEM_WRITE, 1'b0, 64'h0000_0000_1234_5678);
    check(seen_flag, 1'b1);
    check(t[6] - t[5], 1);
    check(t[7], -1);
    check(seen_wdata, 64'h1234_5678_1234_5678);
    check(seen_be, 8'h0F);
    check(lcmd, CMD_MEM_WRITE);
  endtask

  task automatic test_read_unaligned;
    run_txn(32'h2000_0014, CMD_MEM_READ, 1'b0, 64'h0);
    check(t[6] >= 0 && (t[7] < 0 || t[7] > t[6]), 1'b1);
    check(t[5] - t[6], 1);
    check(seen_ad, {32'h0, seen_word[63:32]});
  endtask

  task automatic test_refused;
    run_txn(32'h3000_0000, CMD_MEM_WRITE, 1'b1, 64'h0);
    check({t[1], t[2]}, {32'hFFFF_FFFF, 32'hFFFF_FFFF});
    run_txn(32'h1000_0000, 4'h2, 1'b0, 64'h0);
    check({t[1], t[5]}, {32'hFFFF_FFFF, 32'hFFFF_FFFF});
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    test_reset();
    test_wide_write();
    test_read_aligned();
    test_read_unaligned();
    test_wide_read();
    test_narrow_write();
    test_refused();
    test_wide_write();
    finish_test();
  end

  initial begin
    #500000;
    n_errors++;
    finish_test();
  end
endmodule // pci_target_wide_local_port_tb_top
